// >>> rtl/pss_sram_port.sv
// synchronous bus port of a pipelined 36-bit static memory
// ==========================================================
`timescale 1ns/1ps
module pss_sram_port import pss_pkg::*; #(
  parameter int ADDR_W = PSS_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:PSS_BURST_W] addrHi,
  input wire logic burstStartBit0,
  input wire logic burstStartBit1,
  input wire logic processorAddrStrobeN,
  input wire logic controllerAddrStrobeN,
  input wire logic burstAdvanceN,
  input wire logic [PSS_LANES-1:0] byteLaneWriteSelN,
  input wire logic laneWriteEnableN,
  input wire logic allLanesWriteN,
  input wire logic pipelinedSelectN,
  input wire logic depthSelectHi,
  input wire logic depthSelectLoN,
  input wire logic interleaveOrder,
  input wire logic outputEnableN,
  input wire logic sleepRequest,
  input wire logic [PSS_LANES*PSS_BYTE_W-1:0] dataIn,
  input wire logic [PSS_LANES-1:0] laneNinthBitsIn,
  output logic [PSS_LANES*PSS_BYTE_W-1:0] dataOut,
  output logic dataOe,
  output logic [PSS_LANES-1:0] laneNinthBitsOut,
  output logic laneNinthBitsOe
);
  // ==========================================================
  // state
  typedef struct packed {
    pss_mode_t mode;
    logic [ADDR_W-PSS_BURST_W-1:0] baseHi;
    logic [PSS_BURST_W-1:0] start;
    logic [PSS_BURST_W-1:0] cnt;
    logic ord;
    logic [ADDR_W-1:0] rdAddr;
    logic rdV0;
    logic rdV1;
    logic wrEn;
    logic [PSS_LANES-1:0] wrLanes;
    logic [ADDR_W-1:0] wrAddr;
    logic [PSS_WORD_W-1:0] wrData;
    logic [PSS_WORD_W-1:0] dout;
    logic doe;
    logic oeS1;
    logic oeS2;
    logic slS1;
    logic slS2;
    logic ordS1;
    logic ordS2;
  } pss_state_t;

  pss_state_t st_r;
  pss_state_t st_nxt;
  logic [PSS_WORD_W-1:0] rdData;
  logic [PSS_WORD_W-1:0] inWord;
  logic [PSS_LANES*PSS_BYTE_W-1:0] outBytes;
  logic [PSS_LANES-1:0] outNinth;

  // ==========================================================
  // lane packing: each lane is {ninth bit, byte}
  genvar gi;
  generate
    for (gi = 0; gi < PSS_LANES; gi++) begin : g_pack
      assign inWord[gi*PSS_LANE_W +: PSS_LANE_W] =
        {laneNinthBitsIn[gi], dataIn[gi*PSS_BYTE_W +: PSS_BYTE_W]};
      assign outBytes[gi*PSS_BYTE_W +: PSS_BYTE_W] =
        st_r.dout[gi*PSS_LANE_W +: PSS_BYTE_W];
      assign outNinth[gi] = st_r.dout[gi*PSS_LANE_W + PSS_BYTE_W];
    end
  endgenerate

  // ==========================================================
  // bus decode
  logic selOk;
  logic procLoad;
  logic ctrlLoad;
  logic load;
  logic deselLoad;
  logic wrCycle;
  logic [PSS_LANES-1:0] lanes;
  logic [PSS_BURST_W-1:0] lowAddr;

  always_comb begin
    selOk = !pipelinedSelectN && depthSelectHi && !depthSelectLoN;
    // processor strobe is ignored while the pipelined select is high
    procLoad = !processorAddrStrobeN && !pipelinedSelectN;
    ctrlLoad = !controllerAddrStrobeN && !procLoad;
    load = (procLoad || ctrlLoad) && !st_r.slS2;
    // selects count only when an address is loaded
    deselLoad = load && !selOk;
    // global write wins; lane selects only count with lane enable low
    if (!allLanesWriteN) begin
      lanes = PSS_ALL_LANES;
    end else if (!laneWriteEnableN) begin
      lanes = ~byteLaneWriteSelN;
    end else begin
      lanes = PSS_NO_LANES;
    end
    // a processor-strobe load is always a read cycle
    wrCycle = (lanes != PSS_NO_LANES) && !procLoad;
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // asynchronous pins, two flops before use
    st_nxt.oeS1 = !outputEnableN;
    st_nxt.oeS2 = st_r.oeS1;
    st_nxt.slS1 = sleepRequest;
    st_nxt.slS2 = st_r.slS1;
    st_nxt.ordS1 = interleaveOrder;
    st_nxt.ordS2 = st_r.ordS1;
    st_nxt.rdV0 = 1'b0;
    st_nxt.wrEn = 1'b0;
    unique case (st_r.mode)
      PSS_DESEL, PSS_ACTIVE: begin
        if (st_r.slS2) begin
          st_nxt.mode = PSS_SLEEP;
        end else if (load) begin
          st_nxt.mode = selOk ? PSS_ACTIVE : PSS_DESEL;
          st_nxt.baseHi = addrHi;
          st_nxt.start = {burstStartBit1, burstStartBit0};
          st_nxt.cnt = PSS_CNT_ZERO;
          st_nxt.ord = st_r.ordS2;
        end else if (st_r.mode == PSS_ACTIVE && !burstAdvanceN) begin
          // two-bit wrap keeps the step inside the four-word group
          st_nxt.cnt = st_r.cnt + PSS_CNT_STEP;
        end
      end
      PSS_SLEEP: begin
        // a fresh load is needed after waking
        if (!st_r.slS2) begin
          st_nxt.mode = PSS_DESEL;
        end
      end
    endcase
    lowAddr = st_nxt.ord ? (st_nxt.start ^ st_nxt.cnt)
                         : (st_nxt.start + st_nxt.cnt);
    if (st_nxt.mode == PSS_ACTIVE) begin
      if (wrCycle) begin
        // captured here, committed next edge with no outside timing
        st_nxt.wrEn = 1'b1;
        st_nxt.wrLanes = lanes;
        st_nxt.wrAddr = {st_nxt.baseHi, lowAddr};
        st_nxt.wrData = inWord;
      end else begin
        st_nxt.rdV0 = 1'b1;
        st_nxt.rdAddr = {st_nxt.baseHi, lowAddr};
      end
    end
    // read pipe: address reg, array reg, output reg gives 3-1-1-1
    st_nxt.rdV1 = st_r.rdV0;
    if (st_r.rdV1) begin
      st_nxt.dout = rdData;
    end
    // a deselect or sleep drops the pipe so the pins release next edge
    if (deselLoad || st_r.slS2) begin
      st_nxt.rdV1 = 1'b0;
    end
    // drive only with fresh read data, never in the first clock
    st_nxt.doe = st_r.rdV1 && st_r.oeS2 && !deselLoad && !st_r.slS2;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{mode: PSS_DESEL, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // storage
  pss_mem #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(st_r.wrEn),
    .wrAddr(st_r.wrAddr),
    .wrLanes(st_r.wrLanes),
    .wrData(st_r.wrData),
    .rdEn(st_r.rdV0),
    .rdAddr(st_r.rdAddr),
    .rdData(rdData)
  );

  assign dataOut = outBytes;
  assign laneNinthBitsOut = outNinth;
  assign dataOe = st_r.doe;
  assign laneNinthBitsOe = st_r.doe;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_load_start: assert property (
    load && !st_r.slS2 && st_r.mode != PSS_SLEEP |=>
      st_r.start == $past({burstStartBit1, burstStartBit0}) && st_r.cnt == PSS_CNT_ZERO)
    else $error("load did not take start bits");

  a_hi_hold: assert property (
    !load |=> $stable(st_r.baseHi))
    else $error("upper address moved inside burst");

  a_adv_step: assert property (
    st_r.mode == PSS_ACTIVE && !load && !burstAdvanceN && !st_r.slS2 |=>
      st_r.cnt == $past(st_r.cnt) + PSS_CNT_STEP)
    else $error("advance did not step counter");

  a_adv_hold: assert property (
    !load && burstAdvanceN |=> $stable(st_r.cnt))
    else $error("counter moved without advance");

  a_seq_order: assert property (
    st_r.rdV0 |-> st_r.rdAddr[PSS_BURST_W-1:0] ==
      (st_r.ord ? (st_r.start ^ st_r.cnt) : (st_r.start + st_r.cnt)))
    else $error("burst order wrong");

  a_desel_fast: assert property (
    deselLoad |=> !dataOe ##1 !dataOe)
    else $error("outputs driven after deselect");

  a_oe_source: assert property (
    dataOe |-> $past(st_r.rdV0, 2) && $past(st_r.oeS2))
    else $error("drive without a read in flight");

  a_gw_all: assert property (
    st_nxt.mode == PSS_ACTIVE && !allLanesWriteN && !procLoad |=>
      st_r.wrEn && st_r.wrLanes == PSS_ALL_LANES)
    else $error("global write missed lanes");

  a_lane_sel: assert property (
    st_nxt.mode == PSS_ACTIVE && allLanesWriteN && !laneWriteEnableN && !procLoad &&
      byteLaneWriteSelN != PSS_ALL_LANES |=>
      st_r.wrEn && st_r.wrLanes == ~$past(byteLaneWriteSelN))
    else $error("lane write mask wrong");

  a_write_capture: assert property (
    wrCycle && st_nxt.mode == PSS_ACTIVE |=> st_r.wrEn && st_r.wrData == $past(inWord))
    else $error("write data not captured with its address");

  a_desel_mode: assert property (
    deselLoad && st_r.mode != PSS_SLEEP |=> st_r.mode == PSS_DESEL && !st_r.rdV0)
    else $error("deselect did not stop the port");

  a_sel_ignored: assert property (
    st_r.mode == PSS_ACTIVE && !load && !st_r.slS2 |=> st_r.mode == PSS_ACTIVE)
    else $error("selects acted without a load");

  a_oe_masked: assert property (
    !st_r.oeS2 || st_r.slS2 |=> !dataOe)
    else $error("drive while output enable off or asleep");

  a_sleep_quiet: assert property (
    st_r.slS2 |=> !st_r.rdV0 && !st_r.wrEn)
    else $error("bus cycle taken while asleep");

  a_read_pipe: assert property (
    st_r.rdV0 && !deselLoad && !st_r.slS2 |=> st_r.rdV1)
    else $error("read lost in the pipe");

  a_dout_hold: assert property (
    !st_r.rdV1 |=> $stable(st_r.dout))
    else $error("read data changed without a read");

  a_proc_read: assert property (
    procLoad && selOk && !st_r.slS2 && st_r.mode != PSS_SLEEP |=> st_r.rdV0 && !st_r.wrEn)
    else $error("processor strobe load was not a read");

  c_burst4: cover property (
    st_r.rdV0 && st_r.cnt == 2'h3 ##2 dataOe);
  c_gwrite: cover property (st_r.wrEn && st_r.wrLanes == PSS_ALL_LANES);
  c_desel: cover property (dataOe ##1 deselLoad);
  c_sleep: cover property (st_r.mode == PSS_SLEEP);
  c_proc_read: cover property (procLoad && selOk ##3 dataOe);
endmodule

// >>> rtl/pss_pkg.sv
// constants shared by the pipelined sram bus port and its storage array
package pss_pkg;
  // ==========================================================
  // geometry
  localparam int PSS_ADDR_W = 20;
  localparam int PSS_LANES = 4;
  localparam int PSS_LANE_W = 9;
  localparam int PSS_BYTE_W = 8;
  localparam int PSS_WORD_W = PSS_LANES * PSS_LANE_W;
  localparam int PSS_BURST_W = 2;
  // ==========================================================
  // lane masks and counter constants
  localparam logic [PSS_LANES-1:0] PSS_ALL_LANES = 4'hf;
  localparam logic [PSS_LANES-1:0] PSS_NO_LANES = 4'h0;
  localparam logic [PSS_BURST_W-1:0] PSS_CNT_ZERO = 2'h0;
  localparam logic [PSS_BURST_W-1:0] PSS_CNT_STEP = 2'h1;
  // ==========================================================
  // port modes
  typedef enum logic [2:0] {
    PSS_DESEL = 3'h1,
    PSS_ACTIVE = 3'h2,
    PSS_SLEEP = 3'h4
  } pss_mode_t;
endpackage

// >>> rtl/pss_mem.sv
// storage array with per-lane writes and registered read data
`timescale 1ns/1ps
module pss_mem import pss_pkg::*; #(
  parameter int ADDR_W = PSS_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [PSS_LANES-1:0] wrLanes,
  input wire logic [PSS_WORD_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [PSS_WORD_W-1:0] rdData
);
  // ==========================================================
  // array, one word per address, four 9-bit lanes per word
  // one array per lane so that every lane has a single writing process
  genvar gi;
  generate
    for (gi = 0; gi < PSS_LANES; gi++) begin : g_lane
      logic [PSS_LANE_W-1:0] laneMem [0:(1<<ADDR_W)-1];
      logic [PSS_LANE_W-1:0] laneRd_r;

      // unselected lanes keep their contents
      always_ff @(posedge clk) begin
        if (wrEn && wrLanes[gi]) begin
          laneMem[wrAddr] <= wrData[gi*PSS_LANE_W +: PSS_LANE_W];
        end
      end

      // read port, data leaves through a register
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          laneRd_r <= '0;
        end else if (rdEn) begin
          laneRd_r <= laneMem[rdAddr];
        end
      end

      assign rdData[gi*PSS_LANE_W +: PSS_LANE_W] = laneRd_r;
    end
  endgenerate
endmodule

// >>> dv/pss_ctrl_model.sv
// controller model driving the synchronous side of the sram bus port
`timescale 1ns/1ps
module pss_ctrl_model import pss_pkg::*; #(
  parameter int ADDR_W = 8
) (
  output logic [ADDR_W-1:2] addrHi,
  output logic startBit0,
  output logic startBit1,
  output logic procStrobeN,
  output logic ctrlStrobeN,
  output logic advanceN,
  output logic [PSS_LANES-1:0] laneSelN,
  output logic laneEnN,
  output logic allLanesN,
  output logic selN,
  output logic depthHi,
  output logic depthLoN,
  output logic [31:0] dataIn,
  output logic [PSS_LANES-1:0] ninthIn
);
  // ==========================================================
  // one bus cycle, called just after a falling edge
  // stb: 0 none, 1 controller strobe, 2 processor strobe
  task automatic cyc(input int stb, input logic [ADDR_W-1:0] a, input logic burst_advance_n,
    input logic [3:0] bw, input logic lane_write_enable_n, input logic gw, input logic cs,
    input logic [35:0] d);
    logic wr;
    wr = !gw || !lane_write_enable_n;
    procStrobeN = (stb != 2);
    ctrlStrobeN = (stb != 1);
    // outside a load the address is scrambled so a stray load shows up
    {addrHi, startBit1, startBit0} = stb ? a : ~{addrHi, startBit1, startBit0};
    // selects inactive between loads: they must not matter then
    selN = stb ? !cs : 1'b1;
    depthHi = stb ? cs : 1'b0;
    depthLoN = stb ? !cs : 1'b1;
    advanceN = burst_advance_n;
    laneSelN = bw;
    laneEnN = lane_write_enable_n;
    allLanesN = gw;
    for (int i = 0; i < 4; i++) begin
      dataIn[8*i +: 8] = wr ? d[9*i +: 8] : ~dataIn[8*i +: 8];
      ninthIn[i] = wr ? d[9*i+8] : ~ninthIn[i];
    end
  endtask

  initial begin
    {addrHi, startBit1, startBit0} = '0;
    dataIn = '0;
    ninthIn = '0;
    cyc(0, '0, 1'b1, 4'hf, 1'b1, 1'b1, 1'b0, '0);
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the pipelined sram bus port
`timescale 1ns/1ps
module testbench import pss_pkg::*; ;
  logic clk, rst_n, order, oeN, sleep, b0, b1, pStbN, cStbN, advN, bweN, gwN;
  logic ce1N, ce2, ce3N, oe, ninOe;
  logic [7:2] aHi;
  logic [3:0] bwN, ninIn, ninOut;
  logic [31:0] dIn, dOut;
  logic [35:0] mem [0:255];
  int badCount, checkCount;

  pss_sram_port #(.ADDR_W(8)) i_pss_sram_port (.clk(clk), .rst_n(rst_n), .addrHi(aHi),
    .burstStartBit0(b0), .burstStartBit1(b1), .processorAddrStrobeN(pStbN),
    .controllerAddrStrobeN(cStbN), .burstAdvanceN(advN), .byteLaneWriteSelN(bwN),
    .laneWriteEnableN(bweN), .allLanesWriteN(gwN), .pipelinedSelectN(ce1N),
    .depthSelectHi(ce2), .depthSelectLoN(ce3N), .interleaveOrder(order),
    .outputEnableN(oeN), .sleepRequest(sleep), .dataIn(dIn), .laneNinthBitsIn(ninIn),
    .dataOut(dOut), .dataOe(oe), .laneNinthBitsOut(ninOut), .laneNinthBitsOe(ninOe));

  pss_ctrl_model #(.ADDR_W(8)) i_pss_ctrl_model (.addrHi(aHi), .startBit0(b0),
    .startBit1(b1), .procStrobeN(pStbN), .ctrlStrobeN(cStbN), .advanceN(advN),
    .laneSelN(bwN), .laneEnN(bweN), .allLanesN(gwN), .selN(ce1N), .depthHi(ce2),
    .depthLoN(ce3N), .dataIn(dIn), .ninthIn(ninIn));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] seen);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (badCount == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [35:0] seenWord();
    logic [35:0] w;
    for (int i = 0; i < 4; i++) w[9*i +: 9] = {ninOut[i], dOut[8*i +: 8]};
    return w;
  endfunction

  task automatic idle();
    @(negedge clk);
    i_pss_ctrl_model.cyc(0, 8'h00, 1'b1, 4'hf, 1'b1, 1'b1, 1'b0, 36'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] bw, input logic lane_write_enable_n,
    input logic gw, input logic [35:0] d);
    logic [3:0] ln;
    ln = !gw ? 4'hf : (!lane_write_enable_n ? ~bw : 4'h0);
    @(negedge clk);
    i_pss_ctrl_model.cyc(1, a, 1'b1, bw, lane_write_enable_n, gw, 1'b1, d);
    for (int i = 0; i < 4; i++) if (ln[i]) mem[a][9*i +: 9] = d[9*i +: 9];
    idle();
  endtask

  // load, n-1 advances, check each word, then deselect
  task automatic rd(input logic [7:0] a, input int n, input logic ilv, input int stb);
    logic [7:0] x;
    for (int i = 0; i < n + 3; i++) begin
      @(negedge clk);
      if (i >= 3) begin
        x = {a[7:2], ilv ? a[1:0] ^ 2'(i - 3) : a[1:0] + 2'(i - 3)};
        chk("read valid", 36'h3, {34'h0, ninOe, oe});
        chk("read word", mem[x], seenWord());
      end
      i_pss_ctrl_model.cyc(i == 0 ? stb : (i == n + 2 ? 1 : 0), a, i == 0 || i >= n,
        4'hf, 1'b1, 1'b1, i <= n + 1, 36'h0);
    end
    @(negedge clk);
    chk("deselect drive", 36'h0, {34'h0, ninOe, oe});
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_fill();
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i), 4'hf, 1'b1, 1'b0, 36'h1_2345_6780 + 36'(i));
    rd(8'h11, 4, 1'b0, 1);
  endtask

  task automatic sc_interleave();
    order = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'h13, 4, 1'b1, 2);
    order = 1'b0;
  endtask

  task automatic sc_lanes();
    wr(8'h12, 4'he, 1'b0, 1'b1, 36'h9_abcd_ef01);
    wr(8'h13, 4'ha, 1'b0, 1'b1, 36'h5_5555_5555);
    wr(8'h10, 4'h0, 1'b0, 1'b1, 36'h0_f0f0_f0f0);
    wr(8'h11, 4'h5, 1'b1, 1'b1, 36'hf_ffff_ffff);
    rd(8'h12, 4, 1'b0, 1);
  endtask

  task automatic sc_async();
    oeN = 1'b1;
    repeat (3) idle();
    @(negedge clk);
    i_pss_ctrl_model.cyc(1, 8'h10, 1'b1, 4'hf, 1'b1, 1'b1, 1'b1, 36'h0);
    repeat (5) begin
      idle();
      chk("masked drive", 36'h0, {35'h0, oe});
    end
    oeN = 1'b0;
    sleep = 1'b1;
    repeat (3) idle();
    @(negedge clk);
    i_pss_ctrl_model.cyc(1, 8'h10, 1'b1, 4'hf, 1'b1, 1'b0, 1'b1, 36'hd_eade_adde);
    repeat (3) idle();
    chk("sleep drive", 36'h0, {35'h0, oe});
    sleep = 1'b0;
    repeat (3) idle();
    rd(8'h10, 1, 1'b0, 1);
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    badCount++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    order = 1'b0;
    oeN = 1'b0;
    sleep = 1'b0;
    badCount = 0;
    checkCount = 0;
    repeat (5) @(negedge clk);
    chk("reset drive", 36'h0, {34'h0, ninOe, oe});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    sc_fill();
    sc_interleave();
    sc_lanes();
    sc_async();
    conclude();
  end
endmodule
